/* rtl/ext_osc_control.sv */
// ext_osc_control.sv: register file, pin claims, crystal-valid and timer ticks
// assumes: AXI4-Lite master on ref_clk, amplitude detector and external clock
// arrive asynchronously from the analog oscillator pad
`timescale 1ns/10ps
`include "eoc_params.svh"
// Function
// R1 - crystal mode claims port 0 pins 2 and 3 as oscillator terminals
// R2 - capacitor, RC or CMOS mode claims only port 0 pin 3
// R3 - firmware makes crossbar skip oscillator pins and sets their input mode
// R4 - firmware selects oscillator type and frequency field to suit the source
// R5 - external clock divided by eight offered to timers and counter array
// R6 - divided clock resynchronised to system clock, jitter within half a cycle
// R7 - external clock must not exceed system clock when only clocking peripherals
// R8 - firmware waits one millisecond after enabling crystal before reading valid
// R9 - crystal start-up: latches low, analog, enable, wait, poll, then switch
// R10 - tuning-fork crystals need extra settling before trusting valid flag
// R11 - read-only crystal-valid flag reads one only once amplitude is stable
module ext_osc_control (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        extClkPin,
    input  wire logic        ampStablePin,
    output logic             oscTermInClaim,
    output logic             oscTermOutClaim,
    output logic             timerExtTick,
    output logic             counterArrayExtTick,
    output logic             irq
);
    eoc_tick_if tickBus ();

    logic [7:0]  awAddr_r,  awAddr_nxt;
    logic        awHave_r,  awHave_nxt;
    logic [7:0]  wData_r,   wData_nxt;
    logic        wStrb0_r,  wStrb0_nxt;
    logic        wHave_r,   wHave_nxt;
    logic        awready_r, awready_nxt;
    logic        wready_r,  wready_nxt;
    logic        bvalid_r,  bvalid_nxt;
    logic [1:0]  bresp_r,   bresp_nxt;
    logic        arready_r, arready_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic [1:0]  rresp_r,   rresp_nxt;
    logic [2:0]  mode_r,    mode_nxt;
    logic [2:0]  freq_r,    freq_nxt;
    logic [1:0]  sel_r,     sel_nxt;
    logic [1:0]  stat_r,    stat_nxt;
    logic [1:0]  mask_r,    mask_nxt;
    logic        ampA_r,    ampB_r;
    logic        xtalValid_r, xtalValid_nxt;
    logic        termIn_r,  termIn_nxt;
    logic        termOut_r, termOut_nxt;
    logic        tTick_r,   tTick_nxt;
    logic        cTick_r,   cTick_nxt;
    logic        irq_r,     irq_nxt;
    logic [1:0]  statSet;
    logic [1:0]  statClr;
    logic        doWrite;
    eoc_pkg::eoc_src_t src;

    assign src            = eoc_pkg::eoc_decode_mode(mode_r);
    assign tickBus.enable = (src != eoc_pkg::EOC_SRC_OFF);
    assign tickBus.div2   = eoc_pkg::eoc_has_div2(mode_r);

    eoc_ext_divider u_divider (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .extClkPin (extClkPin),
        .tickBus   (tickBus)
    );

    // amplitude detector is analog-side, so it crosses two flops first
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ampA_r <= 1'b0;
            ampB_r <= 1'b0;
        end else begin
            ampA_r <= ampStablePin;
            ampB_r <= ampA_r;
        end
    end

    // bus slave, register file, pin claims and interrupt next-state
    always_comb begin
        awAddr_nxt  = awAddr_r;
        awHave_nxt  = awHave_r;
        wData_nxt   = wData_r;
        wStrb0_nxt  = wStrb0_r;
        wHave_nxt   = wHave_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        mode_nxt    = mode_r;
        freq_nxt    = freq_r;
        sel_nxt     = sel_r;
        mask_nxt    = mask_r;
        statClr     = 2'h0;
        doWrite     = 1'b0;
        // address and data are taken independently, in either order
        if (awvalid && awready_r) begin
            awAddr_nxt = awaddr;
            awHave_nxt = 1'b1;
        end
        if (wvalid && wready_r) begin
            wData_nxt  = wdata[7:0];
            wStrb0_nxt = wstrb[0];
            wHave_nxt  = 1'b1;
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        // commit only once both halves are held and the last response is gone
        if (awHave_r && wHave_r && !bvalid_r) begin
            doWrite    = 1'b1;
            awHave_nxt = 1'b0;
            wHave_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = `EOC_RESP_OKAY;
            // all fields sit in byte lane 0; other lanes are ignored
            unique case (awAddr_r)
                `EOC_OFS_CTRL: if (wStrb0_r) begin
                    mode_nxt = wData_r[`EOC_MODE_LSB +: 3];
                    freq_nxt = wData_r[`EOC_FREQ_LSB +: 3];
                end
                `EOC_OFS_SEL:      if (wStrb0_r) sel_nxt  = wData_r[1:0];
                `EOC_OFS_IRQ_STAT: if (wStrb0_r) statClr  = wData_r[1:0];
                `EOC_OFS_IRQ_MASK: if (wStrb0_r) mask_nxt = wData_r[1:0];
                default:           bresp_nxt = `EOC_RESP_SLVERR;
            endcase
        end
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 32'h0000_0000;
            rresp_nxt  = `EOC_RESP_OKAY;
            unique case (araddr)
                `EOC_OFS_CTRL: begin
                    rdata_nxt[`EOC_VALID_BIT]       = xtalValid_r; // R11
                    rdata_nxt[`EOC_MODE_LSB +: 3]   = mode_r;
                    rdata_nxt[`EOC_FREQ_LSB +: 3]   = freq_r;
                end
                `EOC_OFS_SEL:      rdata_nxt[1:0] = sel_r;
                `EOC_OFS_IRQ_STAT: rdata_nxt[1:0] = stat_r;
                `EOC_OFS_IRQ_MASK: rdata_nxt[1:0] = mask_r;
                default:           rresp_nxt = `EOC_RESP_SLVERR;
            endcase
        end
        awready_nxt = !awHave_nxt && !doWrite;
        wready_nxt  = !wHave_nxt && !doWrite;
        arready_nxt = !rvalid_nxt;

        // valid only in crystal mode and only after stable amplitude
        xtalValid_nxt = (src == eoc_pkg::EOC_SRC_XTAL) && ampB_r; // R11
        // crystal takes both terminals, other active modes only the output
        termIn_nxt  = (src == eoc_pkg::EOC_SRC_XTAL); // R1
        termOut_nxt = (src != eoc_pkg::EOC_SRC_OFF);  // R2
        // divided clock routed to whichever consumer selected it
        tTick_nxt = tickBus.tick && sel_r[`EOC_SEL_TIMER_BIT]; // R5
        cTick_nxt = tickBus.tick && sel_r[`EOC_SEL_CNT_BIT];   // R5

        // valid edges are events; a set in the clearing cycle wins
        statSet = 2'h0;
        statSet[`EOC_IRQ_UP_BIT]   = xtalValid_nxt && !xtalValid_r;
        statSet[`EOC_IRQ_DOWN_BIT] = !xtalValid_nxt && xtalValid_r;
        stat_nxt = (stat_r & ~statClr) | statSet;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            awAddr_r    <= 8'h00;
            awHave_r    <= 1'b0;
            wData_r     <= 8'h00;
            wStrb0_r    <= 1'b0;
            wHave_r     <= 1'b0;
            awready_r   <= 1'b0;
            wready_r    <= 1'b0;
            bvalid_r    <= 1'b0;
            bresp_r     <= `EOC_RESP_OKAY;
            arready_r   <= 1'b0;
            rvalid_r    <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            rresp_r     <= `EOC_RESP_OKAY;
            mode_r      <= `EOC_CTRL_RST;
            freq_r      <= `EOC_CTRL_RST;
            sel_r       <= `EOC_SEL_RST;
            stat_r      <= `EOC_IRQ_RST;
            mask_r      <= `EOC_IRQ_RST;
            xtalValid_r <= 1'b0;
            termIn_r    <= 1'b0;
            termOut_r   <= 1'b0;
            tTick_r     <= 1'b0;
            cTick_r     <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            awAddr_r    <= awAddr_nxt;
            awHave_r    <= awHave_nxt;
            wData_r     <= wData_nxt;
            wStrb0_r    <= wStrb0_nxt;
            wHave_r     <= wHave_nxt;
            awready_r   <= awready_nxt;
            wready_r    <= wready_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            arready_r   <= arready_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            mode_r      <= mode_nxt;
            freq_r      <= freq_nxt;
            sel_r       <= sel_nxt;
            stat_r      <= stat_nxt;
            mask_r      <= mask_nxt;
            xtalValid_r <= xtalValid_nxt;
            termIn_r    <= termIn_nxt;
            termOut_r   <= termOut_nxt;
            tTick_r     <= tTick_nxt;
            cTick_r     <= cTick_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign awready             = awready_r;
    assign wready              = wready_r;
    assign bvalid              = bvalid_r;
    assign bresp               = bresp_r;
    assign arready             = arready_r;
    assign rvalid              = rvalid_r;
    assign rdata               = rdata_r;
    assign rresp               = rresp_r;
    assign oscTermInClaim      = termIn_r;
    assign oscTermOutClaim     = termOut_r;
    assign timerExtTick        = tTick_r;
    assign counterArrayExtTick = cTick_r;
    assign irq                 = irq_r;

    chk_xtal_both_pins: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
        (src == eoc_pkg::EOC_SRC_XTAL) |=> (oscTermInClaim && oscTermOutClaim))
        else $error("crystal mode did not claim both terminals");

    chk_single_pin: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        (src inside {eoc_pkg::EOC_SRC_CMOS, eoc_pkg::EOC_SRC_RC, eoc_pkg::EOC_SRC_CAP})
        |=> (oscTermOutClaim && !oscTermInClaim))
        else $error("single-pin mode claimed the input terminal");

    chk_valid_needs_xtal: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
        xtalValid_r |-> ($past(src) == eoc_pkg::EOC_SRC_XTAL) && $past(ampB_r))
        else $error("crystal valid without stable crystal amplitude");

    chk_tick_routing: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
        (tickBus.tick && sel_r[`EOC_SEL_TIMER_BIT]) |=> timerExtTick)
        else $error("selected timer tick lost");

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
        irq == (|(stat_r & mask_r)))
        else $error("interrupt level differs from unmasked status");

endmodule : ext_osc_control

/* rtl/eoc_params.svh */
// eoc_params.svh: register offsets, field positions, reset values and counts
// assumes: included by bare name from the external oscillator control files
`ifndef EOC_PARAMS_SVH
`define EOC_PARAMS_SVH

// byte addresses on the 32-bit register bus
`define EOC_OFS_CTRL      8'h00
`define EOC_OFS_SEL       8'h04
`define EOC_OFS_IRQ_STAT  8'h08
`define EOC_OFS_IRQ_MASK  8'h0C

// ext_osc_control_reg fields
`define EOC_FREQ_LSB      0
`define EOC_MODE_LSB      4
`define EOC_VALID_BIT     7

// clock select fields
`define EOC_SEL_TIMER_BIT 0
`define EOC_SEL_CNT_BIT   1

// interrupt status fields
`define EOC_IRQ_UP_BIT    0
`define EOC_IRQ_DOWN_BIT  1

// reset values
`define EOC_CTRL_RST      3'h0
`define EOC_SEL_RST       2'h0
`define EOC_IRQ_RST       2'h0

// external clock division
`define EOC_EXT_DIV       5'h08

// bus answers
`define EOC_RESP_OKAY     2'h0
`define EOC_RESP_SLVERR   2'h2

`endif

/* rtl/eoc_pkg.sv */
// eoc_pkg.sv: types and mode decoding for the external oscillator control
// assumes: used by qualified name only, never imported
package eoc_pkg;

    // kinds of external source selected by the mode field
    typedef enum {
        EOC_SRC_OFF,
        EOC_SRC_CMOS,
        EOC_SRC_RC,
        EOC_SRC_CAP,
        EOC_SRC_XTAL
    } eoc_src_t;

    // mode field decode: 00x off, 01x cmos, 100 rc, 101 cap, 11x crystal
    function automatic eoc_src_t eoc_decode_mode(input logic [2:0] mode);
        eoc_src_t src;
        src = EOC_SRC_OFF;
        unique case (mode)
            3'h0, 3'h1: src = EOC_SRC_OFF;
            3'h2, 3'h3: src = EOC_SRC_CMOS;
            3'h4:       src = EOC_SRC_RC;
            3'h5:       src = EOC_SRC_CAP;
            3'h6, 3'h7: src = EOC_SRC_XTAL;
        endcase
        return src;
    endfunction : eoc_decode_mode

    // odd cmos and crystal codes insert the divide-by-two stage
    function automatic logic eoc_has_div2(input logic [2:0] mode);
        return (mode == 3'h3) || (mode == 3'h7);
    endfunction : eoc_has_div2

endpackage : eoc_pkg

/* rtl/eoc_tick_if.sv */
// eoc_tick_if.sv: control and tick between the top and the external divider
// assumes: both ends run on ref_clk
`timescale 1ns/10ps
interface eoc_tick_if;
    logic enable;
    logic div2;
    logic tick;

    modport src (input enable, input div2, output tick);
    modport ctl (output enable, output div2, input tick);
endinterface : eoc_tick_if

/* rtl/eoc_ext_divider.sv */
// eoc_ext_divider.sv: synchronises the external clock and divides it by eight, or by sixteen with div2
// assumes: external clock no faster than ref_clk, single ref_clk domain
`timescale 1ns/10ps
`include "eoc_params.svh"
module eoc_ext_divider (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic extClkPin,
    eoc_tick_if.src   tickBus
);
    logic       syncA_r,  syncA_nxt;
    logic       syncB_r,  syncB_nxt;
    logic       prevB_r,  prevB_nxt;
    logic [4:0] edgeCnt_r, edgeCnt_nxt;
    logic       tick_r,   tick_nxt;
    logic [4:0] limit;

    // two-flop synchroniser; sampling on ref_clk bounds jitter to half a cycle
    always_comb begin
        syncA_nxt   = extClkPin;
        syncB_nxt   = syncA_r;
        prevB_nxt   = syncB_r;
        limit       = tickBus.div2 ? (`EOC_EXT_DIV << 1) : `EOC_EXT_DIV;
        edgeCnt_nxt = edgeCnt_r;
        tick_nxt    = 1'b0;
        if (!tickBus.enable) begin
            edgeCnt_nxt = 5'h00;
        end else if (syncB_r && !prevB_r) begin
            // count rising edges; one tick per eight (sixteen with div2)  R6
            // at-or-above, so dropping div2 mid-count cannot run on to a wrap
            if (edgeCnt_r >= limit - 5'h01) begin
                edgeCnt_nxt = 5'h00;
                tick_nxt    = 1'b1; // R5
            end else begin
                edgeCnt_nxt = edgeCnt_r + 5'h01;
            end
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_r   <= 1'b0;
            syncB_r   <= 1'b0;
            prevB_r   <= 1'b0;
            edgeCnt_r <= 5'h00;
            tick_r    <= 1'b0;
        end else begin
            syncA_r   <= syncA_nxt;
            syncB_r   <= syncB_nxt;
            prevB_r   <= prevB_nxt;
            edgeCnt_r <= edgeCnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    assign tickBus.tick = tick_r;

    // a tick is one cycle wide and never closer than a synchronised edge pair
    chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
        tick_r |=> !tick_r [*8])
        else $error("divided tick repeated too soon");

    // a tick follows only a sampled rising edge of the external clock
    chk_tick_cause: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
        tick_r |-> $past(syncB_r && !prevB_r && tickBus.enable))
        else $error("tick without a synchronised edge");

endmodule : eoc_ext_divider

/* verification/eoc_osc_model.sv */
// eoc_osc_model.sv: external clock source and amplitude detector beside the pad
// assumes: bench sets run, xtalOn and the half period; no tie to ref_clk
`timescale 1ns/10ps
module eoc_osc_model #(
    parameter int STABLE_NS = 1_200_000
) (
    input  wire logic run,
    input  wire logic xtalOn,
    input  int        halfNs,
    output logic      extClk,
    output logic      ampStable
);
    // source held low while stopped, never faster than ref_clk
    always begin
        if (run) #(halfNs) extClk = ~extClk;
        else begin
            extClk = 1'b0;
            @(run);
        end
    end

    // detector reports stable only after a long settling span
    always begin
        ampStable = 1'b0;
        wait (xtalOn);
        #(STABLE_NS);
        if (xtalOn) ampStable = 1'b1;
        wait (!xtalOn);
    end
endmodule : eoc_osc_model

/* verification/external_oscillator_control_test.sv */
// external_oscillator_control_test.sv: self-checking bench for the oscillator control top
// assumes: design and eoc_osc_model compiled first, one 20 MHz clock
`timescale 1ns/10ps
`include "eoc_params.svh"
module external_oscillator_control_test;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd, wd;
    logic [3:0]  wstrb = 4'h1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic        oscTermInClaim, oscTermOutClaim, timerExtTick, counterArrayExtTick;
    logic        extClk, ampStable, extRun = 1'b0, xtalOn = 1'b0;
    int          halfNs = 100, cyc = 0, errorCnt = 0, cmpCount = 0, polls;
    logic [7:0]  ofs [4] = '{`EOC_OFS_CTRL, `EOC_OFS_SEL, `EOC_OFS_IRQ_STAT, `EOC_OFS_IRQ_MASK};

    ext_osc_control u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .extClkPin(extClk), .ampStablePin(ampStable),
        .oscTermInClaim(oscTermInClaim), .oscTermOutClaim(oscTermOutClaim), .timerExtTick(timerExtTick),
        .counterArrayExtTick(counterArrayExtTick), .irq(irq)
    );
    eoc_osc_model u_osc (.run(extRun), .xtalOn(xtalOn), .halfNs(halfNs), .extClk(extClk), .ampStable(ampStable));

    // clock and cycle count
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] expVal);
        cmpCount++;
        if (seen !== expVal) begin
            errorCnt++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, expVal);
        end
    endtask : check

    task automatic completeRun();
        $display("compares %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : completeRun

    // ready sampled at negedge so the handshake edge is known without a race
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone, wDone, awSeen, wSeen, bSeen;
        awDone = 1'b0;
        wDone = 1'b0;
        bSeen = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(negedge ref_clk);
            awSeen = awready && !awDone;
            wSeen = wready && !wDone;
            @(posedge ref_clk);
            if (awSeen) awvalid <= 1'b0;
            if (wSeen) wvalid <= 1'b0;
            awDone = awDone | awSeen;
            wDone = wDone | wSeen;
        end
        bready <= 1'b1;
        while (!bSeen) begin
            @(negedge ref_clk);
            bSeen = bvalid;
            r = bresp;
            @(posedge ref_clk);
        end
        bready <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!seen) begin
            @(negedge ref_clk);
            seen = arready;
            @(posedge ref_clk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        seen = 1'b0;
        while (!seen) begin
            @(negedge ref_clk);
            seen = rvalid;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
        end
        rready <= 1'b0;
    endtask : axiRead

    function automatic logic [31:0] expCtrl(input logic [2:0] m, input logic [2:0] f, input logic v);
        return {24'h0, v, m, 1'b0, f};
    endfunction : expCtrl

    // crystal takes both terminals, every other live source only the output one
    function automatic logic [1:0] expClaims(input logic [2:0] m);
        return {m >= 3'h6, m >= 3'h2};
    endfunction : expClaims

    // gap between ticks; half a cycle of jitter at each end
    task automatic measureTicks(input int div, input logic cntOn);
        int last;
        real ideal;
        last = -1;
        ideal = div * 2.0 * halfNs / 50.0;
        for (int k = 0; k < 6; k++) begin
            do begin
                @(negedge ref_clk);
                check(counterArrayExtTick, cntOn & timerExtTick);
            end while (timerExtTick !== 1'b1);
            if (last >= 0) check((cyc - last <= ideal + 1.0) && (cyc - last >= ideal - 1.0), 1'b1);
            last = cyc;
        end
    endtask : measureTicks

    // hang guard, about twice the expected run
    initial begin
        #3_000_000;
        errorCnt++;
        completeRun();
    end

    initial begin
        void'($urandom(88));
        halfNs = 60 + $urandom_range(90);
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // all registers clear after reset, then an unmapped place
        foreach (ofs[i]) begin
            axiRead(ofs[i], rd, rsp);
            check(rsp, `EOC_RESP_OKAY);
            check(rd, 32'h0000_0000);
        end
        wd = $urandom;
        axiRead(8'h10 + 8'($urandom_range(59) * 4), rd, rsp);
        check(rsp, `EOC_RESP_SLVERR);
        check(rd, 32'h0000_0000);
        axiWrite(8'hF0, wd, rsp);
        check(rsp, `EOC_RESP_SLVERR);
        // every mode code: pin claims and readback, flag low with no amplitude
        for (int m = 0; m < 8; m++) begin
            wd = $urandom;
            wd[6:4] = 3'(m);
            axiWrite(`EOC_OFS_CTRL, wd, rsp);
            repeat (2) @(negedge ref_clk);
            check({oscTermInClaim, oscTermOutClaim}, expClaims(3'(m)));
            axiRead(`EOC_OFS_CTRL, rd, rsp);
            check(rd, expCtrl(3'(m), wd[2:0], 1'b0));
        end
        // a write with byte lane 0 disabled is answered but changes nothing
        wstrb <= 4'h0;
        axiWrite(`EOC_OFS_CTRL, 32'h0000_0000, rsp);
        wstrb <= 4'h1;
        check(rsp, `EOC_RESP_OKAY);
        axiRead(`EOC_OFS_CTRL, rd, rsp);
        check(rd, expCtrl(3'h7, wd[2:0], 1'b0));
        // cmos source at both consumers, then divide-by-two at the timer only
        extRun <= 1'b1;
        axiWrite(`EOC_OFS_SEL, 32'h0000_0003, rsp);
        axiWrite(`EOC_OFS_CTRL, 32'h0000_0025, rsp);
        measureTicks(8, 1'b1);
        axiWrite(`EOC_OFS_SEL, 32'h0000_0001, rsp);
        axiWrite(`EOC_OFS_CTRL, 32'h0000_0035, rsp);
        measureTicks(16, 1'b0);
        // crystal start: enable crystal mode, wait, then poll
        axiWrite(`EOC_OFS_CTRL, 32'h0000_0067, rsp);
        xtalOn <= 1'b1;
        axiRead(`EOC_OFS_CTRL, rd, rsp);
        check(rd[7], 1'b0);
        repeat (20000) @(posedge ref_clk);
        polls = 0;
        do begin
            axiRead(`EOC_OFS_CTRL, rd, rsp);
            polls++;
        end while (rd[7] !== 1'b1 && polls < 4000);
        check(rd, expCtrl(3'h6, 3'h7, 1'b1));
        axiRead(`EOC_OFS_IRQ_STAT, rd, rsp);
        check(irq, 1'b0);
        check(rd, 32'h0000_0001);
        // mask only the rise event, then unmask both, clear by writing one
        axiWrite(`EOC_OFS_IRQ_MASK, 32'h0000_0002, rsp);
        repeat (2) @(negedge ref_clk);
        check(irq, 1'b0);
        axiWrite(`EOC_OFS_IRQ_MASK, 32'h0000_0003, rsp);
        repeat (2) @(negedge ref_clk);
        check(irq, 1'b1);
        axiWrite(`EOC_OFS_IRQ_STAT, 32'h0000_0001, rsp);
        repeat (2) @(negedge ref_clk);
        check(irq, 1'b0);
        // leaving crystal mode drops the flag and raises the fall event
        axiWrite(`EOC_OFS_CTRL, 32'h0000_0020, rsp);
        repeat (4) @(negedge ref_clk);
        check(irq, 1'b1);
        axiRead(`EOC_OFS_CTRL, rd, rsp);
        check(rd, expCtrl(3'h2, 3'h0, 1'b0));
        axiRead(`EOC_OFS_IRQ_STAT, rd, rsp);
        check(rd, 32'h0000_0002);
        xtalOn <= 1'b0;
        completeRun();
    end
endmodule : external_oscillator_control_test
